/* File: cgi_defs.vh */
// Constants shared by the counter bus interface files
`ifndef CGI_DEFS_VH
`define CGI_DEFS_VH
`define CGI_MSG_LAST 5'd20
`define CGI_IDX_SIGN 5'd2
`define CGI_IDX_MANT 4'd3
`define CGI_IDX_EXPL 5'd15
`define CGI_IDX_EXPS 5'd16
`define CGI_IDX_EXPT 5'd17
`define CGI_IDX_EXPU 5'd18
`define CGI_IDX_CR 5'd19
`define CGI_EXP_BIAS 9'd99
`define CGI_LAD_GRP 2'b01
`define CGI_TAD_GRP 2'b10
`define CGI_MSG_UNL 7'h3f
`define CGI_FUNC_LAST 5'd18
`define CGI_MSG_LLO 7'h11
`define CGI_MSG_SPE 7'h18
`define CGI_MSG_SPD 7'h19
`define CGI_MSG_GTL 7'h01
`define CGI_CH_CR 8'h0d
`define CGI_CH_LF 8'h0a
`define CGI_CH_SP 8'h20
`define CGI_CH_COMMA 8'h2c
`define CGI_CH_SEMI 8'h3b
`define CGI_CH_PLUS 8'h2b
`define CGI_CH_MINUS 8'h2d
`define CGI_CH_DOT 8'h2e
`define CGI_CH_ZERO 8'h30
`define CGI_CH_NINE 8'h39
`define CGI_CH_A 8'h41
`define CGI_CH_Z 8'h5a
`define CGI_CH_E 8'h45
`define CGI_CH_S 8'h53
`define CGI_CH_R 8'h52
`define CGI_SRQ_RESET 3'b100
`define CGI_SRQ_MEAS 0
`define CGI_SRQ_STD 1
`define CGI_SRQ_ERR 2
`define CGI_ERR_NONE 3'd0
`define CGI_ERR_PHASE 3'd1
`define CGI_ERR_RANGE 3'd2
`define CGI_ERR_OVF 3'd3
`define CGI_ERR_ENTRY 3'd4
`define CGI_ERR_SYNTAX 3'd5
`endif

/* File: cgi_buf2.v */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cgi_buf2 #(
    parameter W = 8
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_in_valid,
    input wire [W-1:0] i_in_data,
    output reg o_in_ready,
    output reg o_out_valid,
    output reg [W-1:0] o_out_data,
    input wire i_out_ready
);
    reg [W-1:0] d1;
    reg [1:0] cnt;
    reg [1:0] next_cnt;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;

    always @* begin
        next_cnt = cnt;
        if (push && !pop)
            next_cnt = cnt + 2'd1;
        else if (pop && !push)
            next_cnt = cnt - 2'd1;
    end

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= 2'd0;
            d1 <= {W{1'b0}};
            o_out_data <= {W{1'b0}};
            o_out_valid <= 1'b0;
            o_in_ready <= 1'b1;
        end else begin
            cnt <= next_cnt;
            o_out_valid <= (next_cnt != 2'd0);
            o_in_ready <= (next_cnt != 2'd2);
            if (pop)
                o_out_data <= (cnt == 2'd2) ? d1 : i_in_data;
            else if (push && cnt == 2'd0)
                o_out_data <= i_in_data;
            if (push && (cnt == 2'd2 || (cnt == 2'd1 && !pop)))
                d1 <= i_in_data;
        end
    end
endmodule // cgi_buf2
`default_nettype wire

/* File: cgi_cmd_mem.v */
// Deferred command string store with registered read data
`timescale 1ns/1ps
`default_nettype none
module cgi_cmd_mem #(
    parameter W = 8,
    parameter AW = 6
) (
    input wire i_clk,
    input wire i_wr_en,
    input wire [AW-1:0] i_wr_addr,
    input wire [W-1:0] i_wr_data,
    input wire [AW-1:0] i_rd_addr,
    output reg [W-1:0] o_rd_data
);
    reg [W-1:0] mem [0:(1<<AW)-1];

    always @(posedge i_clk) begin
        if (i_wr_en)
            mem[i_wr_addr] <= i_wr_data;
        o_rd_data <= mem[i_rd_addr];
    end
endmodule // cgi_cmd_mem
`default_nettype wire

/* File: cgi_top.v */
// Bus interface of the counter: commands, results, status and addressing
`include "cgi_defs.vh"
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Deferred commands are stored and run after a string terminator or an immediate command.
// - An immediate command acts at once and releases stored deferred ones.
// - Result is 21 characters: letters, sign, 12 mantissa, E, exponent, CR LF.
// - Sent exponent is always a multiple of three, decimal point shifted.
// - Special function 81 puts spaces in the two letter positions.
// - Two letters name the function or the recalled item.
// - Service request on completion, standard change, error, mix, or never.
// - After power-on only errors raise a service request.
// - Status byte bits 0 to 2 hold the error number.
// - Status bits 3 to 7: standard change, ready, error, request, gate.
// - Error codes 1 to 5; codes 1 to 3 leave no result to send.
// - A recalled value never raises a reading-ready request.
// - Errors 2, 3 clear on good result, 4 on good entry, 1 on agreement.
// - Syntax error: run up to fault, swallow rest, clear on next command.
// - Data bytes with attention false count only while listener.
// - Unsupported attention bytes are accepted and ignored.
// - Own listen and talk addresses come from five address switches.
// - Listen address: listener, not talker, remote only with REN true.
// - Talk address: talker, not listener, local state unchanged.
// - Another device's talk address ends talker state.
// - Lockout disables the local key; REN false clears it, back to local.
// - Talked with no result buffered: wait for the next result.
// - After poll enable send status byte; after disable send results.
module cgi_top #(
    parameter AW = 6
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire [4:0] i_addr_sw,
    input wire i_ren,
    input wire i_rx_valid,
    input wire [7:0] i_rx_data,
    input wire i_rx_atn,
    input wire i_rx_eoi,
    output reg o_rx_ready,
    output reg o_tx_valid,
    output reg [7:0] o_tx_data,
    output reg o_tx_eoi,
    input wire i_tx_ready,
    output reg o_srq,
    output reg o_listener,
    output reg o_talker,
    output reg o_remote,
    output reg o_lockout,
    output wire o_cmd_valid,
    output wire [7:0] o_cmd_data,
    input wire i_cmd_ready,
    output reg o_cmd_exec,
    input wire i_res_valid,
    input wire i_res_sign,
    input wire [43:0] i_res_mant,
    input wire [3:0] i_res_dp,
    input wire signed [7:0] i_res_exp,
    input wire [4:0] i_res_func,
    input wire i_res_recall,
    input wire i_sf81,
    input wire i_std_change,
    input wire i_gate_open,
    input wire i_err_phase,
    input wire i_err_range,
    input wire i_err_ovf,
    input wire i_err_entry,
    input wire i_freq_match,
    input wire i_mode_change,
    input wire i_entry_ok
);
    localparam RP_IDLE = 2'd0;
    localparam RP_READ = 2'd1;
    localparam RP_PUSH = 2'd2;
    localparam RP_DONE = 2'd3;
    localparam TX_IDLE = 2'd0;
    localparam TX_MSG = 2'd1;
    localparam TX_STB = 2'd2;

    // Letter pairs for measured and recalled items, code 0 leftmost
    localparam [303:0] LTR_TABLE =
        "FAFCRARCTITAPHPACKUTRSLALBMXMZDTSFMSGS";
    function [15:0] cgi_letters;
        input [4:0] code;
        reg [4:0] rev;
        begin
            rev = `CGI_FUNC_LAST - code;
            if (code > `CGI_FUNC_LAST)
                cgi_letters = {`CGI_CH_SP, `CGI_CH_SP};
            else
                cgi_letters = LTR_TABLE[rev * 16 +: 16];
        end
    endfunction

    // Result held for the talker
    reg res_full;
    reg res_sign;
    reg [43:0] res_mant;
    reg [3:0] res_dp;
    reg res_exp_neg;
    reg [6:0] res_exp_mag;
    reg [4:0] res_func;
    reg res_sf81;

    // Character at position idx of the outgoing message
    function [7:0] cgi_char;
        input [4:0] idx;
        reg [15:0] lt;
        reg [3:0] pos;
        reg [3:0] dig;
        reg [3:0] nib;
        begin
            lt = cgi_letters(res_func);
            pos = idx[3:0] - `CGI_IDX_MANT;
            dig = (pos < res_dp) ? pos : pos - 4'd1;
            nib = res_mant[(4'd10 - dig) * 4 +: 4];
            if (idx < `CGI_IDX_SIGN)
                cgi_char = res_sf81 ? `CGI_CH_SP :
                    (idx[0] ? lt[7:0] : lt[15:8]);
            else if (idx == `CGI_IDX_SIGN)
                cgi_char = res_sign ? `CGI_CH_MINUS : `CGI_CH_PLUS;
            else if (idx < `CGI_IDX_EXPL)
                cgi_char = (pos == res_dp) ? `CGI_CH_DOT :
                    (`CGI_CH_ZERO | {4'h0, nib});
            else if (idx == `CGI_IDX_EXPL)
                cgi_char = `CGI_CH_E;
            else if (idx == `CGI_IDX_EXPS)
                cgi_char = res_exp_neg ? `CGI_CH_MINUS : `CGI_CH_PLUS;
            else if (idx == `CGI_IDX_EXPT)
                cgi_char = `CGI_CH_ZERO | {1'b0, res_exp_mag / 7'd10};
            else if (idx == `CGI_IDX_EXPU)
                cgi_char = `CGI_CH_ZERO | {1'b0, res_exp_mag % 7'd10};
            else if (idx == `CGI_IDX_CR)
                cgi_char = `CGI_CH_CR;
            else
                cgi_char = `CGI_CH_LF;
        end
    endfunction

    // Exponent brought down to a multiple of three
    wire [8:0] exp_biased = {i_res_exp[7], i_res_exp} + `CGI_EXP_BIAS;
    wire [8:0] exp_rem = exp_biased % 9'd3;
    wire signed [7:0] exp_adj = i_res_exp - $signed(exp_rem[7:0]);
    wire [7:0] exp_abs = exp_adj[7] ? -exp_adj : exp_adj;

    // Receive side
    reg [AW-1:0] wr_cnt;
    reg [AW-1:0] rd_ptr;
    reg [1:0] rp_state;
    reg discard;
    reg syn_pend;
    reg [7:0] hist1;
    reg [7:0] hist2;
    reg [7:0] hist3;
    reg [2:0] srq_mask;
    reg spms;
    wire [7:0] mem_rd;
    wire buf_in_ready;
    wire rx_take = i_rx_valid && o_rx_ready;
    wire [6:0] rx7 = i_rx_data[6:0];
    wire dab = rx_take && !i_rx_atn && o_listener;
    wire is_digit = i_rx_data >= `CGI_CH_ZERO && i_rx_data <= `CGI_CH_NINE;
    wire is_upper = i_rx_data >= `CGI_CH_A && i_rx_data <= `CGI_CH_Z;
    wire is_filler = i_rx_data == `CGI_CH_SP ||
        i_rx_data == `CGI_CH_COMMA || i_rx_data == `CGI_CH_SEMI;
    wire is_legal = is_digit || is_upper || i_rx_data == `CGI_CH_DOT ||
        i_rx_data == `CGI_CH_PLUS || i_rx_data == `CGI_CH_MINUS;
    wire is_term = i_rx_data == `CGI_CH_LF || i_rx_eoi;
    wire is_srs = hist3 == `CGI_CH_S && hist2 == `CGI_CH_R &&
        hist1 == `CGI_CH_S && is_digit && !i_rx_data[3];
    wire mem_full = &wr_cnt;
    wire store = dab && !discard && is_legal && !is_srs && !mem_full;
    wire syn_err = dab && !discard && !is_filler &&
        i_rx_data != `CGI_CH_CR && i_rx_data != `CGI_CH_LF &&
        (!is_legal || mem_full);
    wire run_now = dab && (is_term || (is_srs && !discard));
    wire last_eoi = dab && i_rx_eoi && !discard && is_legal;

    cgi_cmd_mem #(
        .W(8),
        .AW(AW)
    ) u_mem (
        .i_clk(i_clk),
        .i_wr_en(store),
        .i_wr_addr(wr_cnt),
        .i_wr_data(i_rx_data),
        .i_rd_addr(rd_ptr),
        .o_rd_data(mem_rd)
    );

    cgi_buf2 #(
        .W(8)
    ) u_buf (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_in_valid(rp_state == RP_PUSH),
        .i_in_data(mem_rd),
        .o_in_ready(buf_in_ready),
        .o_out_valid(o_cmd_valid),
        .o_out_data(o_cmd_data),
        .i_out_ready(i_cmd_ready)
    );

    // Command string store and replay
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_cnt <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            rp_state <= RP_IDLE;
            discard <= 1'b0;
            syn_pend <= 1'b0;
            hist1 <= 8'h00;
            hist2 <= 8'h00;
            hist3 <= 8'h00;
            srq_mask <= `CGI_SRQ_RESET;
            o_rx_ready <= 1'b1;
            o_cmd_exec <= 1'b0;
        end else begin
            o_cmd_exec <= 1'b0;
            if (dab && !is_filler) begin
                hist3 <= hist2;
                hist2 <= hist1;
                hist1 <= i_rx_data;
            end
            if (dab && is_srs && !discard)
                srq_mask <= i_rx_data[2:0];
            if (syn_err)
                discard <= 1'b1;
            else if (dab && is_term)
                discard <= 1'b0;
            if (syn_err)
                syn_pend <= 1'b1;
            else if (store || (dab && is_srs && !discard))
                syn_pend <= 1'b0;
            case (rp_state)
                RP_IDLE: begin
                    if (store)
                        wr_cnt <= wr_cnt + {{(AW-1){1'b0}}, 1'b1};
                    if (dab && is_srs && !discard)
                        wr_cnt <= wr_cnt - {{(AW-2){1'b0}}, 2'd3};
                    if (run_now) begin
                        rd_ptr <= {AW{1'b0}};
                        rp_state <= RP_READ;
                        o_rx_ready <= 1'b0;
                    end
                end
                RP_READ: begin
                    if (rd_ptr == wr_cnt)
                        rp_state <= RP_DONE;
                    else if (buf_in_ready)
                        rp_state <= RP_PUSH;
                end
                RP_PUSH: begin
                    rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
                    rp_state <= RP_READ;
                end
                RP_DONE: begin
                    wr_cnt <= {AW{1'b0}};
                    hist1 <= 8'h00;
                    o_cmd_exec <= 1'b1;
                    o_rx_ready <= 1'b1;
                    rp_state <= RP_IDLE;
                end
                default: rp_state <= RP_IDLE;
            endcase
        end
    end

    // Addressing, remote and lockout
    wire my_lad = rx7 == {`CGI_LAD_GRP, i_addr_sw};
    wire my_tad = rx7 == {`CGI_TAD_GRP, i_addr_sw};
    wire cmd_take = rx_take && i_rx_atn;

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_listener <= 1'b0;
            o_talker <= 1'b0;
            o_remote <= 1'b0;
            o_lockout <= 1'b0;
            spms <= 1'b0;
        end else begin
            if (cmd_take) begin
                if (my_lad) begin
                    o_listener <= 1'b1;
                    o_talker <= 1'b0;
                    if (i_ren)
                        o_remote <= 1'b1;
                end else if (my_tad) begin
                    o_talker <= 1'b1;
                    o_listener <= 1'b0;
                end else if (rx7 == `CGI_MSG_UNL) begin
                    o_listener <= 1'b0;
                end else if (rx7[6:5] == `CGI_TAD_GRP) begin
                    o_talker <= 1'b0;
                end else if (rx7 == `CGI_MSG_LLO) begin
                    o_lockout <= 1'b1;
                end else if (rx7 == `CGI_MSG_SPE) begin
                    spms <= 1'b1;
                end else if (rx7 == `CGI_MSG_SPD) begin
                    spms <= 1'b0;
                end else if (rx7 == `CGI_MSG_GTL && o_listener) begin
                    o_remote <= 1'b0;
                end
                // Anything else is handshaken and dropped
            end
            if (!i_ren) begin
                o_remote <= 1'b0;
                o_lockout <= 1'b0;
            end
        end
    end

    // Error number, sticky status and service request
    reg [2:0] err_code;
    reg [2:0] next_err;
    reg std_flag;
    reg rdy_flag;
    wire meas_ok = i_res_valid && !i_res_recall;
    wire err_evt = i_err_phase || i_err_range || i_err_ovf ||
        i_err_entry || syn_err;
    wire srq_evt = (srq_mask[`CGI_SRQ_MEAS] && meas_ok) ||
        (srq_mask[`CGI_SRQ_STD] && i_std_change) ||
        (srq_mask[`CGI_SRQ_ERR] && err_evt);
    wire [7:0] stb = {i_gate_open, o_srq, err_code != `CGI_ERR_NONE,
        rdy_flag, std_flag, err_code};
    reg [1:0] tx_state;
    reg [4:0] tx_idx;
    wire tx_take = o_tx_valid && i_tx_ready;
    wire stb_sent = tx_take && tx_state == TX_STB;

    always @* begin
        next_err = err_code;
        case (err_code)
            `CGI_ERR_PHASE:
                if (i_freq_match || i_mode_change)
                    next_err = `CGI_ERR_NONE;
            `CGI_ERR_RANGE, `CGI_ERR_OVF:
                if (meas_ok)
                    next_err = `CGI_ERR_NONE;
            `CGI_ERR_ENTRY:
                if (i_entry_ok)
                    next_err = `CGI_ERR_NONE;
            `CGI_ERR_SYNTAX:
                if (!discard && syn_pend && (store || run_now))
                    next_err = `CGI_ERR_NONE;
            default: next_err = err_code;
        endcase
        if (syn_err)
            next_err = `CGI_ERR_SYNTAX;
        else if (i_err_entry)
            next_err = `CGI_ERR_ENTRY;
        else if (i_err_ovf)
            next_err = `CGI_ERR_OVF;
        else if (i_err_range)
            next_err = `CGI_ERR_RANGE;
        else if (i_err_phase)
            next_err = `CGI_ERR_PHASE;
    end

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            err_code <= `CGI_ERR_NONE;
            std_flag <= 1'b0;
            rdy_flag <= 1'b0;
            o_srq <= 1'b0;
        end else begin
            err_code <= next_err;
            if (i_std_change)
                std_flag <= 1'b1;
            else if (stb_sent)
                std_flag <= 1'b0;
            if (meas_ok)
                rdy_flag <= 1'b1;
            else if (stb_sent)
                rdy_flag <= 1'b0;
            if (srq_evt)
                o_srq <= 1'b1;
            else if (stb_sent)
                o_srq <= 1'b0;
        end
    end

    // Result capture and talker output
    wire lose_res = i_err_phase || i_err_range || i_err_ovf;
    wire can_talk = o_talker && !i_rx_atn;

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            res_full <= 1'b0;
            res_sign <= 1'b0;
            res_mant <= 44'h0;
            res_dp <= 4'h0;
            res_exp_neg <= 1'b0;
            res_exp_mag <= 7'h0;
            res_func <= 5'h0;
            res_sf81 <= 1'b0;
            tx_state <= TX_IDLE;
            tx_idx <= 5'h0;
            o_tx_valid <= 1'b0;
            o_tx_data <= 8'h00;
            o_tx_eoi <= 1'b0;
        end else begin
            if (lose_res && tx_state != TX_MSG) begin
                res_full <= 1'b0;
            end else if (i_res_valid && tx_state != TX_MSG) begin
                res_full <= 1'b1;
                res_sign <= i_res_sign;
                res_mant <= i_res_mant;
                res_dp <= i_res_dp + exp_rem[3:0];
                res_exp_neg <= exp_adj[7];
                res_exp_mag <= exp_abs[6:0];
                res_func <= i_res_func;
                res_sf81 <= i_sf81;
            end
            case (tx_state)
                TX_IDLE: begin
                    if (can_talk && spms) begin
                        tx_state <= TX_STB;
                        o_tx_valid <= 1'b1;
                        o_tx_data <= stb;
                        o_tx_eoi <= 1'b0;
                    end else if (can_talk && res_full && !i_res_valid &&
                        !lose_res) begin
                        tx_state <= TX_MSG;
                        tx_idx <= 5'h0;
                        o_tx_valid <= 1'b1;
                        o_tx_data <= cgi_char(5'h0);
                        o_tx_eoi <= 1'b0;
                    end
                end
                TX_MSG: begin
                    if (!can_talk) begin
                        tx_state <= TX_IDLE;
                        o_tx_valid <= 1'b0;
                    end else if (tx_take && tx_idx == `CGI_MSG_LAST) begin
                        tx_state <= TX_IDLE;
                        o_tx_valid <= 1'b0;
                        o_tx_eoi <= 1'b0;
                        res_full <= 1'b0;
                    end else if (tx_take) begin
                        tx_idx <= tx_idx + 5'h1;
                        o_tx_data <= cgi_char(tx_idx + 5'h1);
                        o_tx_eoi <= (tx_idx + 5'h1) == `CGI_MSG_LAST;
                    end
                end
                TX_STB: begin
                    if (tx_take || !can_talk) begin
                        tx_state <= TX_IDLE;
                        o_tx_valid <= 1'b0;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end
endmodule // cgi_top
`default_nettype wire

/* File: cgi_partner.sv */
// Far-side sinks: bus listener and measurement engine
`timescale 1ns/1ps
`default_nettype none
module cgi_partner (
    input wire logic i_clk,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_eoi,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_data,
    output logic o_tx_ready,
    output logic o_cmd_ready
);
    logic [8:0] tx_q[$];
    logic [7:0] cmd_q[$];
    // Both sinks stall at random
    always @(posedge i_clk) begin
        if (i_tx_valid && o_tx_ready)
            tx_q.push_back({i_tx_eoi, i_tx_data});
        if (i_cmd_valid && o_cmd_ready)
            cmd_q.push_back(i_cmd_data);
        o_tx_ready <= $urandom % 3 != 0;
        o_cmd_ready <= $urandom % 2 != 0;
    end
endmodule // cgi_partner
`default_nettype wire

/* File: cgi_top_chk.sv */
// Port checker for the counter bus interface
`timescale 1ns/1ps
`default_nettype none
module cgi_top_chk (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [4:0] i_addr_sw,
    input wire logic i_ren,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_atn,
    input wire logic o_rx_ready,
    input wire logic o_tx_valid,
    input wire logic [7:0] o_tx_data,
    input wire logic i_tx_ready,
    input wire logic o_listener,
    input wire logic o_talker,
    input wire logic o_remote,
    input wire logic o_lockout,
    input wire logic o_cmd_valid,
    input wire logic [7:0] o_cmd_data,
    input wire logic i_cmd_ready
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Attention byte taken this cycle
    wire logic cb = i_rx_valid && o_rx_ready && i_rx_atn;
    wire logic lad = cb && i_rx_data[6:0] == {2'b01, i_addr_sw};
    wire logic tad = cb && i_rx_data[6:5] == 2'b10;
    wire logic own = i_rx_data[4:0] == i_addr_sw;
    listen_addr_a:
        assert property (lad && i_ren |=> o_listener && !o_talker && o_remote)
            else $error("listen address");
    talk_addr_a:
        assert property (tad && own && i_ren |=> o_talker && !o_listener
            && o_remote == $past(o_remote)) else $error("talk address");
    other_talk_a:
        assert property (o_talker && tad && !own |=> !o_talker)
            else $error("other talker");
    lockout_set_a:
        assert property (cb && i_rx_data[6:0] == 7'h11 && i_ren |=> o_lockout)
            else $error("lockout");
    ren_false_a:
        assert property (!i_ren |=> !o_remote && !o_lockout)
            else $error("ren false");
    addr_excl_a:
        assert property (!(o_talker && o_listener)) else $error("both roles");
    tx_hold_a:
        assert property (o_tx_valid && !i_tx_ready && o_talker && !i_rx_atn
            |=> o_tx_valid && $stable(o_tx_data)) else $error("tx hold");
    cmd_hold_a:
        assert property (o_cmd_valid && !i_cmd_ready
            |=> o_cmd_valid && $stable(o_cmd_data)) else $error("cmd hold");
endmodule // cgi_top_chk
bind cgi_top cgi_top_chk chk_u (.*);
`default_nettype wire

/* File: test_counter_gpib_interface.sv */
// Self-checking bench for the counter bus interface
`timescale 1ns/1ps
`default_nettype none
module test_counter_gpib_interface;
    localparam logic [4:0] SW = 5'h0b;
    logic clk = 0, rst_b = 0, ren = 1, rxv = 0, atn = 0, res_v = 0;
    logic sign = 0, recall = 0, sf81 = 0;
    logic [7:0] rxd = 0, ev = 0;
    logic [43:0] mant = 0;
    logic [3:0] dp = 1;
    logic signed [7:0] ex = 0;
    logic [4:0] fn = 0;
    wire logic rxr, txv, txe, txr, srq, lis, tlk, rem, llo, cmv, cmr, exe;
    wire logic [7:0] txd, cmd;
    int num_errors = 0, comparisons = 0;
    string exp_s;
    cgi_top dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_addr_sw(SW),
        .i_ren(ren), .i_rx_valid(rxv), .i_rx_data(rxd), .i_rx_atn(atn),
        .i_rx_eoi(1'b0), .o_rx_ready(rxr), .o_tx_valid(txv),
        .o_tx_data(txd), .o_tx_eoi(txe), .i_tx_ready(txr), .o_srq(srq),
        .o_listener(lis), .o_talker(tlk), .o_remote(rem), .o_lockout(llo),
        .o_cmd_valid(cmv), .o_cmd_data(cmd), .i_cmd_ready(cmr),
        .o_cmd_exec(exe), .i_res_valid(res_v), .i_res_sign(sign),
        .i_res_mant(mant), .i_res_dp(dp), .i_res_exp(ex), .i_res_func(fn),
        .i_res_recall(recall), .i_sf81(sf81), .i_std_change(ev[0]),
        .i_gate_open(1'b0), .i_err_phase(ev[1]), .i_err_range(ev[2]),
        .i_err_ovf(ev[3]), .i_err_entry(ev[4]), .i_freq_match(ev[5]),
        .i_mode_change(ev[6]), .i_entry_ok(ev[7]));
    cgi_partner p_u (.i_clk(clk), .i_tx_valid(txv), .i_tx_data(txd),
        .i_tx_eoi(txe), .i_cmd_valid(cmv), .i_cmd_data(cmd),
        .o_tx_ready(txr), .o_cmd_ready(cmr));
    initial forever #5 clk = ~clk;
    task automatic end_of_test();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, want);
        end
    endtask
    task automatic hang();
        num_errors++;
        end_of_test();
    endtask
    task automatic put(input logic [7:0] b, input logic a);
        int i = 0;
        rxv <= 1'b1;
        rxd <= b;
        atn <= a;
        do @(posedge clk); while (!rxr && i++ < 500);
        if (i > 500) hang();
    endtask
    task automatic idle();
        rxv <= 1'b0;
        atn <= 1'b0;
        @(posedge clk);
    endtask
    task automatic str(input string s);
        foreach (s[i]) put(s[i], 1'b0);
        idle();
    endtask
    task automatic waitq(input int n, input bit c);
        int i = 0;
        while ((c ? p_u.cmd_q.size() : p_u.tx_q.size()) < n && i++ < 3000)
            @(posedge clk);
        if (i > 3000) hang();
    endtask
    // Expected message
    function automatic string msg();
        string l = "FAFCRARCTITAPHPACKUTRSLALBMXMZDTSFMSGS";
        string d = $sformatf("%h", mant);
        int k = (int'(ex) % 3 + 3) % 3;
        int e = int'(ex) - k;
        return $sformatf("%s%s%s.%sE%s%02d\r\n",
            sf81 ? "  " : l.substr(2 * fn, 2 * fn + 1), sign ? "-" : "+",
            d.substr(0, dp + k - 1), d.substr(dp + k, 10),
            e < 0 ? "-" : "+", e < 0 ? -e : e);
    endfunction
    task automatic result(input logic rc);
        logic [43:0] m;
        for (int i = 0; i < 11; i++)
            m[4*i+:4] = 4'($urandom % 10);
        mant <= m;
        fn <= 5'($urandom % 19);
        dp <= 4'($urandom % 8 + 1);
        ex <= 8'(int'($urandom % 61) - 30);
        sign <= 1'($urandom);
        sf81 <= 1'($urandom);
        recall <= rc;
        res_v <= 1'b1;
        @(posedge clk);
        res_v <= 1'b0;
        exp_s = msg();
    endtask
    task automatic cmpmsg();
        waitq(21, 0);
        foreach (exp_s[i])
            chk(p_u.tx_q[i], {i == 20, exp_s[i]});
        p_u.tx_q.delete();
    endtask
    initial begin
        void'($urandom(32'h05cf));
        repeat (3) @(posedge clk);
        chk({rxr, txv, srq, lis, tlk, rem, llo, cmv, exe}, 9'h100);
        rst_b <= 1'b1;
        put({3'b001, SW}, 1'b1);
        idle();
        chk({lis, tlk, rem}, 3'b101);
        result(1'b0);
        repeat (3) @(posedge clk);
        chk(srq, 1'b0);
        str("FA");
        repeat (6) @(posedge clk);
        chk(p_u.cmd_q.size(), 0);
        str("SRS5");
        waitq(2, 1);
        chk({p_u.cmd_q[0], p_u.cmd_q[1]}, "FA");
        str("FA,\n");
        waitq(4, 1);
        chk({p_u.cmd_q[2], p_u.cmd_q[3]}, "FA");
        $display("command test done");
        put({3'b010, SW}, 1'b1);
        idle();
        chk({lis, tlk, rem}, 3'b011);
        cmpmsg();
        repeat (4) begin
            result(1'b0);
            cmpmsg();
        end
        chk(srq, 1'b1);
        $display("result test done");
        ev <= 8'h11;
        @(posedge clk);
        ev <= 8'h00;
        put(8'h18, 1'b1);
        idle();
        waitq(1, 0);
        chk(p_u.tx_q[0] & 9'h1ef, 9'h06c);
        put(8'h19, 1'b1);
        idle();
        p_u.tx_q.delete();
        ev <= 8'h80;
        @(posedge clk);
        ev <= 8'h00;
        repeat (20) @(posedge clk);
        chk(txv, 1'b0);
        result(1'b1);
        cmpmsg();
        chk(srq, 1'b0);
        $display("status test done");
        put({3'b010, SW ^ 5'h01}, 1'b1);
        put(8'h11, 1'b1);
        idle();
        chk({tlk, llo}, 2'b01);
        ren <= 1'b0;
        repeat (2) @(posedge clk);
        chk({rem, llo}, 2'b00);
        $display("address test done");
        end_of_test();
    end
endmodule // test_counter_gpib_interface
`default_nettype wire
